// [verilog/sltc_regs.vh]
// Purpose: register map and field constants for the serial link tx configuration bank
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: printed offsets are not all multiples of four, so they are indices (byte address = 4 * index)
`ifndef SLTC_REGS_VH
`define SLTC_REGS_VH

// register indices and byte addresses
`define SLTC_IDX_LINK_ENABLE 12'h200
`define SLTC_IDX_SOFT_SYNC 12'h203
`define SLTC_IDX_LINK_CONTROL 12'h204
`define SLTC_IDX_TEST 12'h205
`define SLTC_IDX_DID 12'h206
`define SLTC_IDX_FRAME_END_CHARACTER 12'h207
`define SLTC_IDX_STATUS 12'h208
`define SLTC_ADDR_W 14
`define SLTC_ADDR_LINK_ENABLE 14'h0800
`define SLTC_ADDR_SOFT_SYNC 14'h080c
`define SLTC_ADDR_LINK_CONTROL 14'h0810
`define SLTC_ADDR_TEST 14'h0814
`define SLTC_ADDR_DID 14'h0818
`define SLTC_ADDR_FRAME_END_CHARACTER 14'h081c
`define SLTC_ADDR_STATUS 14'h0820

// reset values
`define SLTC_RST_LINK_ENABLE 1'h1
`define SLTC_RST_SOFT_SYNC 1'h1
`define SLTC_RST_LINK_CONTROL 5'h03
`define SLTC_RST_TEST 5'h00
`define SLTC_RST_DID 8'h00
`define SLTC_RST_FRAME_END_CHARACTER 2'h0

// link_control fields
`define SLTC_LC_SCR 0
`define SLTC_LC_FMT 1
`define SLTC_LC_SYNC_HI 3
`define SLTC_LC_SYNC_LO 2
`define SLTC_LC_UPPER 4
`define SLTC_LC_W 5

// sync source codes
`define SLTC_SYNC_PIN 2'h0
`define SLTC_SYNC_TSTAMP 2'h1
`define SLTC_SYNC_SOFT 2'h2

// test pattern codes
`define SLTC_TP_W 5
`define SLTC_TP_NORMAL 5'h00
`define SLTC_TP_PRBS7 5'h01
`define SLTC_TP_PRBS15 5'h02
`define SLTC_TP_PRBS23 5'h03
`define SLTC_TP_RAMP 5'h04
`define SLTC_TP_TRANSPORT 5'h05
`define SLTC_TP_D215 5'h06
`define SLTC_TP_K285 5'h07
`define SLTC_TP_ILA 5'h08
`define SLTC_TP_RPAT 5'h09
`define SLTC_TP_LOW 5'h0a
`define SLTC_TP_HIGH 5'h0b
`define SLTC_TP_PRBS9 5'h0d
`define SLTC_TP_PRBS31 5'h0e
`define SLTC_TP_CLOCK 5'h0f
`define SLTC_TP_K287 5'h10
`define SLTC_CLOCK_WORD 16'h00ff

// test pattern one-hot select bits
`define SLTC_PS_W 16
`define SLTC_PS_PRBS7 0
`define SLTC_PS_PRBS15 1
`define SLTC_PS_PRBS23 2
`define SLTC_PS_RAMP 3
`define SLTC_PS_TRANSPORT 4
`define SLTC_PS_D215 5
`define SLTC_PS_K285 6
`define SLTC_PS_ILA 7
`define SLTC_PS_RPAT 8
`define SLTC_PS_LOW 9
`define SLTC_PS_HIGH 10
`define SLTC_PS_PRBS9 11
`define SLTC_PS_PRBS31 12
`define SLTC_PS_CLOCK 13
`define SLTC_PS_K287 14
`define SLTC_PS_UNSUP 15

// comma characters (8b/10b control codes, K28.y as byte)
`define SLTC_K287 8'hfc
`define SLTC_K281 8'h3c
`define SLTC_K285 8'hbc
`define SLTC_FRAME_END_CHARACTER_RSVD 2'h3
`define SLTC_FRAME_END_CHARACTER_K281 2'h1
`define SLTC_FRAME_END_CHARACTER_K285 2'h2

// lane groups
`define SLTC_LANES 8
`define SLTC_LOWER_LANES 8'h0f
`define SLTC_UPPER_LANES 8'hf0

`endif

// [verilog/sltc_config_regs.v]
// Purpose: configuration register bank for the serial link transmitter, APB slave
// Assumes: one clock pclk at 40 MHz, asynchronous active-low presetn
// Notes: decoded controls leave as plain ports for the link datapath
//
// Functional notes
// - upper select 0: links on lanes 0-3, other lanes powered down.
// - upper select 1: links on lanes 4-7, lanes 0-3 powered down.
// - sync source 0 (default) takes sync request from single-ended pin.
// - sync source 1 takes sync from timestamp pin; receiver enable needed.
// - sync source 2 ignores pins, uses only the software request bit.
// - format bit 0 offset binary, 1 two's complement; resets to 1.
// - in 8b/10b modes scrambler follows its enable bit; resets to 1.
// - in 64b/66b modes data is always scrambled.
// - test codes 0,1,2,3,13,14 give normal, PRBS7/15/23/9/31.
// - test code 4 ramp, 5 transport pattern, 6 repeated D21.5.
// - codes 7, 8, 9, 16 supported only in 8b/10b modes.
// - test code 10 holds outputs low, 11 holds them high.
// - test code 15 sends clock pattern 0x00FF on each lane.
// - identifier is sent in the second alignment multiframe.
// - link A sends identifier, link B identifier plus one.
// - identifier bit 0 forced to zero on write and read.
// - frame end comma K28.7, K28.1, K28.5 for codes 0-2; 3 reserved.
// - end-of-frame comma inserted opportunistically, not every frame.
// - link enable 0 holds link and multiframe counter in reset, powers down.
// - writing 0 to software sync bit requests resynchronization.
`include "sltc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module sltc_config_regs (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // link status inputs from datapath, same clock
    input wire mode_is_64b66b,
    input wire timestamp_receiver_enable,
    input wire multiframe_second,
    input wire frame_boundary,
    input wire comma_opportunity,
    // asynchronous sync pins, active low
    input wire single_ended_sync_pin,
    input wire timestamp_input_pin,
    // link control outputs
    output reg link_enable,
    output reg link_block_reset,
    output reg serializer_power_down,
    output reg link_clock_gate_off,
    output reg [`SLTC_LANES-1:0] link_a_lane_enable,
    output reg [`SLTC_LANES-1:0] link_b_lane_enable,
    output reg sync_request,
    output reg sample_twos_complement,
    output reg scramble_active,
    output reg [`SLTC_PS_W-1:0] pattern_select,
    output reg [7:0] link_a_identifier,
    output reg [7:0] link_b_identifier,
    output reg identifier_valid,
    output reg [7:0] frame_end_comma,
    output reg insert_frame_comma,
    output reg [15:0] clock_pattern_word
);

    reg link_enable_q;
    reg soft_sync_request_q;
    reg [`SLTC_LC_W-1:0] link_control_q;
    reg [`SLTC_TP_W-1:0] link_test_pattern_q;
    reg [7:0] lane_device_identifier_q;
    reg [1:0] frame_end_character_q;
    reg [2:0] se_sync_q;
    reg [2:0] ts_sync_q;
    reg se_sync_level_q;
    reg ts_sync_level_q;
    reg [`SLTC_PS_W-1:0] pattern_d;
    reg [7:0] comma_d;
    reg sync_d;
    reg [31:0] rdata_d;

    wire [`SLTC_ADDR_W-1:0] addr = paddr[`SLTC_ADDR_W-1:0];
    wire upper_lane_select = link_control_q[`SLTC_LC_UPPER];
    wire [1:0] sync_source = link_control_q[`SLTC_LC_SYNC_HI:`SLTC_LC_SYNC_LO];
    wire write_en = psel & penable & pwrite;
    wire addr_hit = (addr == `SLTC_ADDR_LINK_ENABLE) | (addr == `SLTC_ADDR_SOFT_SYNC) |
                    (addr == `SLTC_ADDR_LINK_CONTROL) | (addr == `SLTC_ADDR_TEST) |
                    (addr == `SLTC_ADDR_DID) | (addr == `SLTC_ADDR_FRAME_END_CHARACTER) |
                    (addr == `SLTC_ADDR_STATUS);
    wire upper_hit = (paddr[31:`SLTC_ADDR_W] == {(32-`SLTC_ADDR_W){1'b0}});

    // zero-wait slave; unmapped or misaligned addresses answer with pslverr
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(addr_hit & upper_hit);

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_enable_q <= `SLTC_RST_LINK_ENABLE;
            soft_sync_request_q <= `SLTC_RST_SOFT_SYNC;
            link_control_q <= `SLTC_RST_LINK_CONTROL;
            link_test_pattern_q <= `SLTC_RST_TEST;
            lane_device_identifier_q <= `SLTC_RST_DID;
            frame_end_character_q <= `SLTC_RST_FRAME_END_CHARACTER;
        end else if (write_en && upper_hit) begin
            case (addr)
                `SLTC_ADDR_LINK_ENABLE: link_enable_q <= pwdata[0];
                `SLTC_ADDR_SOFT_SYNC: soft_sync_request_q <= pwdata[0];
                `SLTC_ADDR_LINK_CONTROL: link_control_q <= pwdata[`SLTC_LC_W-1:0];
                `SLTC_ADDR_TEST: link_test_pattern_q <= pwdata[`SLTC_TP_W-1:0];
                `SLTC_ADDR_DID: lane_device_identifier_q <= {pwdata[7:1], 1'b0};
                `SLTC_ADDR_FRAME_END_CHARACTER: frame_end_character_q <= pwdata[1:0];
                default: link_enable_q <= link_enable_q;
            endcase
        end
    end

    // three-stage pin synchronisers; level changes when stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se_sync_q <= 3'h7;
            ts_sync_q <= 3'h7;
            se_sync_level_q <= 1'b1;
            ts_sync_level_q <= 1'b1;
        end else begin
            se_sync_q <= {se_sync_q[1:0], single_ended_sync_pin};
            ts_sync_q <= {ts_sync_q[1:0], timestamp_input_pin};
            if (se_sync_q[1] == se_sync_q[2])
                se_sync_level_q <= se_sync_q[2];
            if (ts_sync_q[1] == ts_sync_q[2])
                ts_sync_level_q <= ts_sync_q[2];
        end
    end

    // sync request select, active high request out
    always @* begin
        sync_d = ~soft_sync_request_q;
        case (sync_source)
            `SLTC_SYNC_PIN: sync_d = sync_d | ~se_sync_level_q;
            `SLTC_SYNC_TSTAMP: sync_d = sync_d | (timestamp_receiver_enable & ~ts_sync_level_q);
            `SLTC_SYNC_SOFT: sync_d = sync_d;
            default: sync_d = sync_d;
        endcase
    end

    // test pattern decode; unsupported or reserved codes raise the unsupported bit
    always @* begin
        pattern_d = {`SLTC_PS_W{1'b0}};
        case (link_test_pattern_q)
            `SLTC_TP_NORMAL: pattern_d = {`SLTC_PS_W{1'b0}};
            `SLTC_TP_PRBS7: pattern_d[`SLTC_PS_PRBS7] = 1'b1;
            `SLTC_TP_PRBS15: pattern_d[`SLTC_PS_PRBS15] = 1'b1;
            `SLTC_TP_PRBS23: pattern_d[`SLTC_PS_PRBS23] = 1'b1;
            `SLTC_TP_PRBS9: pattern_d[`SLTC_PS_PRBS9] = 1'b1;
            `SLTC_TP_PRBS31: pattern_d[`SLTC_PS_PRBS31] = 1'b1;
            `SLTC_TP_RAMP: pattern_d[`SLTC_PS_RAMP] = 1'b1;
            `SLTC_TP_TRANSPORT: pattern_d[`SLTC_PS_TRANSPORT] = 1'b1;
            `SLTC_TP_D215: pattern_d[`SLTC_PS_D215] = 1'b1;
            `SLTC_TP_K285: pattern_d[mode_is_64b66b ? `SLTC_PS_UNSUP : `SLTC_PS_K285] = 1'b1;
            `SLTC_TP_ILA: pattern_d[mode_is_64b66b ? `SLTC_PS_UNSUP : `SLTC_PS_ILA] = 1'b1;
            `SLTC_TP_RPAT: pattern_d[mode_is_64b66b ? `SLTC_PS_UNSUP : `SLTC_PS_RPAT] = 1'b1;
            `SLTC_TP_K287: pattern_d[mode_is_64b66b ? `SLTC_PS_UNSUP : `SLTC_PS_K287] = 1'b1;
            `SLTC_TP_LOW: pattern_d[`SLTC_PS_LOW] = 1'b1;
            `SLTC_TP_HIGH: pattern_d[`SLTC_PS_HIGH] = 1'b1;
            `SLTC_TP_CLOCK: pattern_d[`SLTC_PS_CLOCK] = 1'b1;
            default: pattern_d[`SLTC_PS_UNSUP] = 1'b1;
        endcase
    end

    // frame end comma choice; reserved code falls back to the compliant character
    always @* begin
        case (frame_end_character_q)
            `SLTC_FRAME_END_CHARACTER_K281: comma_d = `SLTC_K281;
            `SLTC_FRAME_END_CHARACTER_K285: comma_d = `SLTC_K285;
            default: comma_d = `SLTC_K287;
        endcase
    end

    // registered control outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_enable <= 1'b0;
            link_block_reset <= 1'b1;
            serializer_power_down <= 1'b1;
            link_clock_gate_off <= 1'b1;
            link_a_lane_enable <= 8'h00;
            link_b_lane_enable <= 8'h00;
            sync_request <= 1'b0;
            sample_twos_complement <= 1'b1;
            scramble_active <= 1'b1;
            pattern_select <= {`SLTC_PS_W{1'b0}};
            link_a_identifier <= 8'h00;
            link_b_identifier <= 8'h00;
            identifier_valid <= 1'b0;
            frame_end_comma <= `SLTC_K287;
            insert_frame_comma <= 1'b0;
            clock_pattern_word <= 16'h0000;
        end else begin
            link_enable <= link_enable_q;
            link_block_reset <= ~link_enable_q;
            serializer_power_down <= ~link_enable_q;
            link_clock_gate_off <= ~link_enable_q;
            if (!link_enable_q) begin
                link_a_lane_enable <= 8'h00;
                link_b_lane_enable <= 8'h00;
            end else if (upper_lane_select) begin
                link_a_lane_enable <= `SLTC_UPPER_LANES;
                link_b_lane_enable <= `SLTC_UPPER_LANES;
            end else begin
                link_a_lane_enable <= `SLTC_LOWER_LANES;
                link_b_lane_enable <= `SLTC_LOWER_LANES;
            end
            sync_request <= link_enable_q & sync_d;
            sample_twos_complement <= link_control_q[`SLTC_LC_FMT];
            scramble_active <= mode_is_64b66b | link_control_q[`SLTC_LC_SCR];
            pattern_select <= pattern_d;
            clock_pattern_word <= pattern_d[`SLTC_PS_CLOCK] ? `SLTC_CLOCK_WORD : 16'h0000;
            link_a_identifier <= lane_device_identifier_q;
            link_b_identifier <= lane_device_identifier_q + 8'h01;
            identifier_valid <= link_enable_q & multiframe_second;
            frame_end_comma <= comma_d;
            // only where datapath has a free slot at a frame edge
            insert_frame_comma <= link_enable_q & ~mode_is_64b66b & frame_boundary & comma_opportunity;
        end
    end

    // read mux
    always @* begin
        rdata_d = 32'h0000_0000;
        case (addr)
            `SLTC_ADDR_LINK_ENABLE: rdata_d[0] = link_enable_q;
            `SLTC_ADDR_SOFT_SYNC: rdata_d[0] = soft_sync_request_q;
            `SLTC_ADDR_LINK_CONTROL: rdata_d[`SLTC_LC_W-1:0] = link_control_q;
            `SLTC_ADDR_TEST: rdata_d[`SLTC_TP_W-1:0] = link_test_pattern_q;
            `SLTC_ADDR_DID: rdata_d[7:0] = lane_device_identifier_q;
            `SLTC_ADDR_FRAME_END_CHARACTER: rdata_d[1:0] = frame_end_character_q;
            `SLTC_ADDR_STATUS: rdata_d[3:0] = {sync_request, pattern_d[`SLTC_PS_UNSUP],
                                              ts_sync_level_q, se_sync_level_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= upper_hit ? rdata_d : 32'h0000_0000;
    end

endmodule
`default_nettype wire

// [tb/sltc_config_regs_sva.sv]
// Purpose: port checks for the link config bank
// Assumes: one clock pclk, presetn async active low
// Notes: bound from the bench top; idle for one edge after reset
`include "sltc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sltc_config_regs_sva (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pslverr,
    // link controls
    input wire mode_is_64b66b,
    input wire link_enable,
    input wire link_block_reset,
    input wire [7:0] link_a_lane_enable,
    input wire [7:0] link_b_lane_enable,
    input wire sync_request,
    input wire scramble_active,
    input wire [15:0] pattern_select,
    input wire [7:0] link_a_identifier,
    input wire [7:0] link_b_identifier,
    input wire [7:0] frame_end_comma,
    input wire [15:0] clock_pattern_word
);
    logic up_q;
    // outputs lag their registers by one edge after release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            up_q <= 1'b0;
        else
            up_q <= 1'b1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !up_q);
    sequence s_mode64;
        mode_is_64b66b ##1 mode_is_64b66b;
    endsequence
    err_phase_a: assert property (
        pslverr |-> psel && penable) else $error("pslverr outside access phase");
    lane_map_a: assert property (
        link_enable |-> link_b_lane_enable == link_a_lane_enable &&
        (link_a_lane_enable == `SLTC_LOWER_LANES || link_a_lane_enable == `SLTC_UPPER_LANES)) else $error("lane map");
    link_off_a: assert property (
        !link_enable |-> link_block_reset && link_a_lane_enable == 8'h00 && !sync_request) else $error("link off");
    scr_64b_a: assert property (
        s_mode64 |-> scramble_active) else $error("64b mode not scrambled");
    tp_64b_a: assert property (
        s_mode64 |-> (pattern_select & 16'h41c0) == 16'h0000) else $error("8b10b pattern in 64b mode");
    tp_onehot_a: assert property (
        $onehot0(pattern_select)) else $error("pattern select not one-hot");
    clk_word_a: assert property (
        clock_pattern_word == (pattern_select[`SLTC_PS_CLOCK] ? `SLTC_CLOCK_WORD : 16'h0000)) else $error("clock word");
    id_pair_a: assert property (
        link_b_identifier == 8'(link_a_identifier + 8'h01) && !link_a_identifier[0]) else $error("identifier pair");
    comma_code_a: assert property (
        frame_end_comma inside {`SLTC_K287, `SLTC_K281, `SLTC_K285}) else $error("frame comma code");
endmodule
`default_nettype wire

// [tb/sltc_rx_model.sv]
// Purpose: receiver side sync sources for the config bank bench
// Assumes: sync pins active low, idle high
// Notes: pins change just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module sltc_rx_model (
    // requests
    input wire logic pclk,
    input wire logic want_se,
    input wire logic want_ts,
    // sync pins
    output logic se_sync_n = 1'b1,
    output logic ts_sync_n = 1'b1
);
    always @(posedge pclk) begin
        se_sync_n <= !want_se;
        ts_sync_n <= !want_ts;
    end
endmodule
`default_nettype wire

// [tb/sltc_config_regs_tb_top.sv]
// Purpose: self-checking bench for the link config bank
// Assumes: 40 MHz pclk, zero-wait apb slave
// Notes: cfg changes settings with the link disabled; the soft sync bit is written with the link enabled
`include "sltc_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sltc_config_regs_tb_top;
    logic pclk, presetn, psel, penable, pwrite, err, want_se, want_ts;
    logic mode_is_64b66b, timestamp_receiver_enable, multiframe_second, frame_boundary, comma_opportunity;
    logic [31:0] paddr, pwdata, q;
    wire pready, pslverr, single_ended_sync_pin, timestamp_input_pin;
    wire link_enable, link_block_reset, serializer_power_down, link_clock_gate_off, sync_request;
    wire sample_twos_complement, scramble_active, identifier_valid, insert_frame_comma;
    wire [7:0] link_a_lane_enable, link_b_lane_enable, link_a_identifier, link_b_identifier, frame_end_comma;
    wire [15:0] pattern_select, clock_pattern_word;
    wire [31:0] prdata;
    int bad_count, num_checks, cycles;
    int ps_idx [18] = '{-1, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 15, 11, 12, 13, 14, 15};
    logic [7:0] commas [4] = '{8'hfc, 8'h3c, 8'hbc, 8'hfc};
    sltc_config_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
        .mode_is_64b66b, .timestamp_receiver_enable, .multiframe_second, .frame_boundary, .comma_opportunity,
        .single_ended_sync_pin, .timestamp_input_pin, .link_enable, .link_block_reset, .serializer_power_down,
        .link_clock_gate_off, .link_a_lane_enable, .link_b_lane_enable, .sync_request, .sample_twos_complement,
        .scramble_active, .pattern_select, .link_a_identifier, .link_b_identifier, .identifier_valid,
        .frame_end_comma, .insert_frame_comma, .clock_pattern_word);
    sltc_rx_model rx (.pclk, .want_se, .want_ts, .se_sync_n(single_ended_sync_pin), .ts_sync_n(timestamp_input_pin));
    task automatic conclude;
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, q);
        cmp("pslverr", 32'h0, err);
    endtask
    task automatic settle;
        repeat (3) @(posedge pclk);
    endtask
    task automatic cfg(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, `SLTC_ADDR_LINK_ENABLE, 32'h0);
        apb(1'b1, a, d);
        apb(1'b1, `SLTC_ADDR_LINK_ENABLE, 32'h1);
        settle;
    endtask
    task automatic sync_is(input logic exp);
        repeat (8) @(posedge pclk);
        cmp("sync_request", exp, sync_request);
    endtask
    task automatic t_reset;
        settle;
        cmp("lanes", 8'h0f, link_a_lane_enable);
        cmp("twos", 1'b1, sample_twos_complement);
        cmp("scramble", 1'b1, scramble_active);
        cmp("comma", 8'hfc, frame_end_comma);
        rdc("control", `SLTC_ADDR_LINK_CONTROL, 32'h03);
        rdc("test", `SLTC_ADDR_TEST, 32'h0);
        rdc("did", `SLTC_ADDR_DID, 32'h0);
        rdc("frame_end_character", `SLTC_ADDR_FRAME_END_CHARACTER, 32'h0);
        rdc("enable", `SLTC_ADDR_LINK_ENABLE, 32'h1);
    endtask
    task automatic t_lanes;
        apb(1'b1, `SLTC_ADDR_LINK_ENABLE, 32'h0);
        settle;
        cmp("off_lanes", 8'h00, link_b_lane_enable);
        cmp("off_power", 1'b1, serializer_power_down & link_clock_gate_off & link_block_reset);
        cfg(`SLTC_ADDR_LINK_CONTROL, 32'h13);
        cmp("upper_a", 8'hf0, link_a_lane_enable);
        cmp("upper_b", 8'hf0, link_b_lane_enable);
        cfg(`SLTC_ADDR_LINK_CONTROL, 32'h00);
        cmp("lower_b", 8'h0f, link_b_lane_enable);
        cmp("twos_off", 1'b0, sample_twos_complement);
        cmp("scr_off", 1'b0, scramble_active);
        mode_is_64b66b <= 1'b1;
        settle;
        cmp("scr_64b", 1'b1, scramble_active);
        mode_is_64b66b <= 1'b0;
        cfg(`SLTC_ADDR_LINK_CONTROL, 32'h03);
    endtask
    task automatic t_patterns;
        for (int c = 0; c < 18; c++) begin
            cfg(`SLTC_ADDR_TEST, c);
            cmp("pattern", ps_idx[c] < 0 ? 32'h0 : 32'h1 << ps_idx[c], pattern_select);
            cmp("clock_word", c == 15 ? 32'h00ff : 32'h0, clock_pattern_word);
        end
        mode_is_64b66b <= 1'b1;
        cfg(`SLTC_ADDR_TEST, 32'h7);
        cmp("pattern_64b", 32'h8000, pattern_select);
        cfg(`SLTC_ADDR_TEST, 32'hff);
        rdc("test_rsvd", `SLTC_ADDR_TEST, 32'h1f);
        mode_is_64b66b <= 1'b0;
        cfg(`SLTC_ADDR_TEST, 32'h0);
    endtask
    task automatic t_ident;
        cfg(`SLTC_ADDR_DID, 32'hff);
        rdc("did_even", `SLTC_ADDR_DID, 32'hfe);
        cmp("id_a", 8'hfe, link_a_identifier);
        cmp("id_b", 8'hff, link_b_identifier);
        multiframe_second <= 1'b1;
        settle;
        cmp("id_valid", 1'b1, identifier_valid);
        multiframe_second <= 1'b0;
        settle;
        cmp("id_idle", 1'b0, identifier_valid);
    endtask
    task automatic t_comma;
        for (int f = 0; f < 4; f++) begin
            cfg(`SLTC_ADDR_FRAME_END_CHARACTER, f);
            cmp("comma", commas[f], frame_end_comma);
        end
        cfg(`SLTC_ADDR_FRAME_END_CHARACTER, 32'h0);
        frame_boundary <= 1'b1;
        settle;
        cmp("no_insert", 1'b0, insert_frame_comma);
        comma_opportunity <= 1'b1;
        settle;
        cmp("insert", 1'b1, insert_frame_comma);
        frame_boundary <= 1'b0;
        comma_opportunity <= 1'b0;
    endtask
    task automatic t_sync;
        want_ts <= 1'b1;
        sync_is(1'b0);
        want_ts <= 1'b0;
        want_se <= 1'b1;
        sync_is(1'b1);
        want_se <= 1'b0;
        timestamp_receiver_enable <= 1'b1;
        cfg(`SLTC_ADDR_LINK_CONTROL, 32'h07);
        want_ts <= 1'b1;
        sync_is(1'b1);
        timestamp_receiver_enable <= 1'b0;
        sync_is(1'b0);
        want_ts <= 1'b0;
        cfg(`SLTC_ADDR_LINK_CONTROL, 32'h0b);
        want_se <= 1'b1;
        sync_is(1'b0);
        apb(1'b1, `SLTC_ADDR_SOFT_SYNC, 32'h0);
        sync_is(1'b1);
        rdc("status", `SLTC_ADDR_STATUS, 32'ha);
        apb(1'b1, `SLTC_ADDR_SOFT_SYNC, 32'h1);
        sync_is(1'b0);
        want_se <= 1'b0;
    endtask
    task automatic t_unmapped;
        apb(1'b0, 32'h0900, 32'h0);
        cmp("unmapped_data", 32'h0, q);
        cmp("unmapped_err", 1'b1, err);
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            conclude;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, mode_is_64b66b, timestamp_receiver_enable} = 6'h0;
        {multiframe_second, frame_boundary, comma_opportunity, want_se, want_ts} = 5'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_lanes;
        t_patterns;
        t_ident;
        t_comma;
        t_sync;
        t_unmapped;
        conclude;
    end
endmodule
bind sltc_config_regs sltc_config_regs_sva chk (.pclk, .presetn, .psel, .penable, .pslverr, .mode_is_64b66b,
    .link_enable, .link_block_reset, .link_a_lane_enable, .link_b_lane_enable, .sync_request, .scramble_active,
    .pattern_select, .link_a_identifier, .link_b_identifier, .frame_end_comma, .clock_pattern_word);
`default_nettype wire
